// [shared/loader_consts.svh]
// command codes, link patterns and timing counts of the loader host
`ifndef LOADER_CONSTS_SVH
`define LOADER_CONSTS_SVH
`define CMD_LOAD_DATA 8'h11
`define CMD_DUMP_CODE 8'h20
`define CMD_DUMP_DATA 8'h21
`define CMD_CRC_CODE 8'h30
`define CMD_CRC_DATA 8'h31
`define CMD_VERIFY_CODE 8'h40
`define CMD_VERIFY_DATA 8'h41
`define CMD_LDVER_CODE 8'h50
`define CMD_LDVER_DATA 8'h51
`define CMD_PAGE_ERASE 8'hE0
`define FILL_BYTE 8'h00
`define TRAILER_BYTE 8'h3E
`define RANGE_PARAMS 8'h02
`define STAT_VALID 2'h3
`define STAT_BUSY 2'h2
`define HEAD_LAST_LOAD 3'h3
`define HEAD_LAST_RANGE 3'h6
`define HEAD_LAST_ERASE 3'h4
`define CRC_BYTES 16'h0002
`define REF_PERIOD_NS 10
`define LINK_PERIOD_NS 80
`define LINK_HALF_CYC (`LINK_PERIOD_NS / (2 * `REF_PERIOD_NS))
`define LINK_SETTLE_CYC 3
`define POLL_LIMIT_DEF 16'hFFFF
`endif

// [shared/loader_pkg.sv]
// state and frame types of the loader host
package loader_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HEAD, ST_BODY, ST_NOP, ST_TRAIL, ST_END
  } state_e;
  typedef enum logic [1:0] {K_LOAD, K_DUMP, K_CRC, K_ERASE} kind_e;
  typedef enum logic [1:0] {SH_IDLE, SH_LOW, SH_HIGH, SH_SETTLE} shift_e;
endpackage : loader_pkg

// [logic/link_byte_shifter.sv]
// byte shifter that makes the link clock and samples data and status
`include "loader_consts.svh"
module link_byte_shifter (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] txByte,
  input wire logic linkDin,
  input wire logic [1:0] linkStatus,
  output logic linkClk,
  output logic linkDout,
  output logic done,
  output logic [7:0] rxByte,
  output logic [1:0] status
);
  localparam logic [3:0] HALF_LAST = 4'(`LINK_HALF_CYC - 1);
  localparam logic [3:0] SETTLE_LAST = 4'(`LINK_SETTLE_CYC - 1);

  logic dinMeta, dinSync;
  logic [1:0] statMeta, statSync;
  loader_pkg::shift_e state, next_state;
  logic [3:0] halfCnt, next_halfCnt;
  logic [2:0] bitCnt, next_bitCnt;
  logic [7:0] shReg, next_shReg, next_rxByte;
  logic next_linkClk, next_linkDout, next_done;
  logic [1:0] next_status;

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dinMeta <= 1'h0;
      dinSync <= 1'h0;
      statMeta <= 2'h0;
      statSync <= 2'h0;
    end
    else
    begin
      dinMeta <= linkDin;
      dinSync <= dinMeta;
      statMeta <= linkStatus;
      statSync <= statMeta;
    end
  end

  // --------------------------------------------------------------
  // shift sequencer, msb first, data changes while clock is low
  // --------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_halfCnt = halfCnt + 4'h1;
    next_bitCnt = bitCnt;
    next_shReg = shReg;
    next_rxByte = rxByte;
    next_linkClk = linkClk;
    next_linkDout = linkDout;
    next_status = status;
    next_done = 1'h0;
    unique case (state)
      loader_pkg::SH_IDLE:
      begin
        next_halfCnt = 4'h0;
        if (start)
        begin
          next_shReg = txByte;
          next_linkDout = txByte[7];
          next_bitCnt = 3'h0;
          next_state = loader_pkg::SH_LOW;
        end
      end
      loader_pkg::SH_LOW:
        if (halfCnt == HALF_LAST)
        begin
          next_halfCnt = 4'h0;
          next_linkClk = 1'h1;
          next_state = loader_pkg::SH_HIGH;
        end
      loader_pkg::SH_HIGH:
        if (halfCnt == HALF_LAST)
        begin
          next_halfCnt = 4'h0;
          next_linkClk = 1'h0;
          next_rxByte = {rxByte[6:0], dinSync};
          if (bitCnt == 3'h7)
            next_state = loader_pkg::SH_SETTLE;
          else
          begin
            next_bitCnt = bitCnt + 3'h1;
            next_shReg = {shReg[6:0], 1'h0};
            next_linkDout = shReg[6];
            next_state = loader_pkg::SH_LOW;
          end
        end
      loader_pkg::SH_SETTLE:
        // status pins settle through the synchroniser first
        if (halfCnt == SETTLE_LAST)
        begin
          next_status = statSync;
          next_done = 1'h1;
          next_state = loader_pkg::SH_IDLE;
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= loader_pkg::SH_IDLE;
      halfCnt <= 4'h0;
      bitCnt <= 3'h0;
      shReg <= 8'h00;
      rxByte <= 8'h00;
      linkClk <= 1'h0;
      linkDout <= 1'h0;
      status <= 2'h0;
      done <= 1'h0;
    end
    else
    begin
      state <= next_state;
      halfCnt <= next_halfCnt;
      bitCnt <= next_bitCnt;
      shReg <= next_shReg;
      rxByte <= next_rxByte;
      linkClk <= next_linkClk;
      linkDout <= next_linkDout;
      status <= next_status;
      done <= next_done;
    end
  end

  clock_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(linkClk) |-> linkClk [*4] ##1 !linkClk)
    else $error("link clock high phase wrong");
  byte_time_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (start && state == loader_pkg::SH_IDLE) |-> ##[60:80] done)
    else $error("byte transfer not finished in time");
endmodule : link_byte_shifter

// [logic/loader_host_engine.sv]
// host engine that frames loader memory commands over the serial link
`include "loader_consts.svh"
module loader_host_engine #(
  parameter logic [15:0] POLL_LIMIT = `POLL_LIMIT_DEF
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmdStart,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdLength,
  input wire logic [7:0] cmdPage,
  input wire logic [7:0] wrData,
  input wire logic wrValid,
  output logic wrTaken,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic [15:0] crcResult,
  output logic cmdBusy,
  output logic cmdDone,
  output logic cmdTimeout,
  output logic linkClk,
  output logic linkDout,
  input wire logic linkDin,
  input wire logic [1:0] linkStatus
);
  loader_pkg::state_e state, next_state;
  loader_pkg::kind_e kind, next_kind;
  logic [7:0] code, next_code, page, next_page;
  logic [15:0] addr, next_addr, len, next_len, cnt, next_cnt;
  logic [15:0] polls, next_polls, next_crcResult;
  logic [2:0] hIdx, next_hIdx;
  logic need, next_need, inFlight, next_inFlight;
  logic shStart, next_shStart, next_wrTaken, next_rdValid;
  logic [7:0] txByte, next_txByte, next_rdData;
  logic next_cmdBusy, next_cmdDone, next_cmdTimeout;
  logic shDone;
  logic [7:0] shRx;
  logic [1:0] shStatus;
  logic loadBody;

  // --------------------------------------------------------------
  // link byte shifter
  // --------------------------------------------------------------
  link_byte_shifter shifter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(shStart),
    .txByte(txByte),
    .linkDin(linkDin),
    .linkStatus(linkStatus),
    .linkClk(linkClk),
    .linkDout(linkDout),
    .done(shDone),
    .rxByte(shRx),
    .status(shStatus)
  );

  // --------------------------------------------------------------
  // framing helpers
  // --------------------------------------------------------------
  // byte of the command header at a given position
  function automatic logic [7:0] headByte(
    input loader_pkg::kind_e k,
    input logic [2:0] idx,
    input logic [7:0] c,
    input logic [15:0] a,
    input logic [15:0] l,
    input logic [7:0] p
  );
    logic [7:0] b;
    b = `FILL_BYTE;
    if (idx == 3'h0)
      b = c;
    else if (k == loader_pkg::K_LOAD)
    begin
      unique case (idx)
        3'h1: b = l[7:0];
        3'h2: b = a[7:0];
        3'h3: b = a[15:8];
        default: b = `FILL_BYTE;
      endcase
    end
    else if (k == loader_pkg::K_ERASE)
    begin
      if (idx == 3'h2)
        b = p;
    end
    else
    begin
      unique case (idx)
        3'h1: b = `RANGE_PARAMS;
        3'h2: b = a[7:0];
        3'h3: b = a[15:8];
        3'h4: b = l[7:0];
        3'h5: b = l[15:8];
        default: b = `FILL_BYTE;
      endcase
    end
    return b;
  endfunction : headByte

  // last header index of each frame kind
  function automatic logic [2:0] headLast(input loader_pkg::kind_e k);
    logic [2:0] n;
    n = `HEAD_LAST_RANGE;
    if (k == loader_pkg::K_LOAD)
      n = `HEAD_LAST_LOAD;
    else if (k == loader_pkg::K_ERASE)
      n = `HEAD_LAST_ERASE;
    return n;
  endfunction : headLast

  // number of body bytes after the header
  function automatic logic [15:0] bodyCount(
    input loader_pkg::kind_e k,
    input logic [15:0] l
  );
    logic [15:0] n;
    unique case (k)
      loader_pkg::K_LOAD: n = {8'h00, l[7:0]};
      loader_pkg::K_DUMP: n = l;
      loader_pkg::K_CRC: n = `CRC_BYTES;
      loader_pkg::K_ERASE: n = 16'h0000;
    endcase
    return n;
  endfunction : bodyCount

  assign loadBody = (state == loader_pkg::ST_BODY) &&
    (kind == loader_pkg::K_LOAD);

  // --------------------------------------------------------------
  // command sequencer
  // --------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_kind = kind;
    next_code = code;
    next_addr = addr;
    next_len = len;
    next_page = page;
    next_cnt = cnt;
    next_polls = polls;
    next_hIdx = hIdx;
    next_need = need;
    next_inFlight = inFlight;
    next_txByte = txByte;
    next_shStart = 1'h0;
    next_wrTaken = 1'h0;
    next_rdData = rdData;
    next_rdValid = 1'h0;
    next_crcResult = crcResult;
    next_cmdBusy = cmdBusy;
    next_cmdDone = 1'h0;
    next_cmdTimeout = cmdTimeout;
    unique case (state)
      loader_pkg::ST_IDLE:
        if (cmdStart)
        begin
          next_state = loader_pkg::ST_HEAD;
          unique case (cmdCode)
            `CMD_LOAD_DATA, `CMD_VERIFY_CODE, `CMD_VERIFY_DATA,
            `CMD_LDVER_CODE, `CMD_LDVER_DATA:
              next_kind = loader_pkg::K_LOAD;
            `CMD_DUMP_CODE, `CMD_DUMP_DATA:
              next_kind = loader_pkg::K_DUMP;
            `CMD_CRC_CODE, `CMD_CRC_DATA:
              next_kind = loader_pkg::K_CRC;
            `CMD_PAGE_ERASE:
              next_kind = loader_pkg::K_ERASE;
            default:
              next_state = loader_pkg::ST_IDLE;
          endcase
          next_code = cmdCode;
          next_addr = cmdAddr;
          if (cmdCode == `CMD_VERIFY_CODE || cmdCode == `CMD_LDVER_CODE)
            next_addr[0] = 1'h0;
          next_len = cmdLength;
          next_page = cmdPage;
          next_hIdx = 3'h0;
          next_polls = 16'h0000;
          next_need = 1'h1;
          next_cmdBusy = (next_state == loader_pkg::ST_HEAD);
          next_cmdTimeout = 1'h0;
        end
      loader_pkg::ST_END:
      begin
        next_cmdDone = 1'h1;
        next_cmdBusy = 1'h0;
        next_state = loader_pkg::ST_IDLE;
      end
      loader_pkg::ST_HEAD, loader_pkg::ST_BODY,
      loader_pkg::ST_NOP, loader_pkg::ST_TRAIL:
        if (need && !inFlight)
        begin
          if (state == loader_pkg::ST_HEAD)
            next_txByte = headByte(kind, hIdx, code, addr, len, page);
          else if (loadBody)
            next_txByte = wrData;
          else
            next_txByte = `FILL_BYTE;
          // load bytes go out only as the source has them
          if (!loadBody || wrValid)
          begin
            next_shStart = 1'h1;
            next_inFlight = 1'h1;
            next_need = 1'h0;
            next_wrTaken = loadBody;
          end
        end
        else if (inFlight && shDone)
        begin
          next_inFlight = 1'h0;
          // resend the same byte while loader busy
          if (shStatus == `STAT_BUSY)
          begin
            next_shStart = 1'h1;
            next_inFlight = 1'h1;
          end
          else
          begin
            next_need = 1'h1;
            if (state == loader_pkg::ST_HEAD)
            begin
              if (hIdx == headLast(kind))
              begin
                next_cnt = bodyCount(kind, len);
                if (next_cnt != 16'h0000)
                  next_state = loader_pkg::ST_BODY;
                else if (kind == loader_pkg::K_LOAD)
                  next_state = loader_pkg::ST_NOP;
                else
                  next_state = loader_pkg::ST_TRAIL;
              end
              else
                next_hIdx = hIdx + 3'h1;
            end
            else if (state == loader_pkg::ST_BODY)
            begin
              // dump bytes handed out as they arrive
              if (kind == loader_pkg::K_DUMP)
              begin
                next_rdData = shRx;
                next_rdValid = 1'h1;
              end
              // checksum low byte first, then high
              if (kind == loader_pkg::K_CRC && cnt == `CRC_BYTES)
                next_crcResult[7:0] = shRx;
              else if (kind == loader_pkg::K_CRC)
                next_crcResult[15:8] = shRx;
              next_cnt = cnt - 16'h0001;
              if (cnt == 16'h0001)
                next_state = (kind == loader_pkg::K_LOAD) ?
                  loader_pkg::ST_NOP : loader_pkg::ST_TRAIL;
            end
            else if (state == loader_pkg::ST_NOP)
              next_state = loader_pkg::ST_TRAIL;
            else
            begin
              // poll the trailer until it reads 3Eh or polls reaches POLL_LIMIT
              if (shRx == `TRAILER_BYTE)
              begin
                next_need = 1'h0;
                next_state = loader_pkg::ST_END;
              end
              else if (polls == POLL_LIMIT)
              begin
                next_need = 1'h0;
                next_cmdTimeout = 1'h1;
                next_state = loader_pkg::ST_END;
              end
              else
                next_polls = polls + 16'h0001;
            end
          end
        end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= loader_pkg::ST_IDLE;
      kind <= loader_pkg::K_LOAD;
      code <= 8'h00;
      addr <= 16'h0000;
      len <= 16'h0000;
      page <= 8'h00;
      cnt <= 16'h0000;
      polls <= 16'h0000;
      hIdx <= 3'h0;
      need <= 1'h0;
      inFlight <= 1'h0;
      txByte <= 8'h00;
      shStart <= 1'h0;
      wrTaken <= 1'h0;
      rdData <= 8'h00;
      rdValid <= 1'h0;
      crcResult <= 16'h0000;
      cmdBusy <= 1'h0;
      cmdDone <= 1'h0;
      cmdTimeout <= 1'h0;
    end
    else
    begin
      state <= next_state;
      kind <= next_kind;
      code <= next_code;
      addr <= next_addr;
      len <= next_len;
      page <= next_page;
      cnt <= next_cnt;
      polls <= next_polls;
      hIdx <= next_hIdx;
      need <= next_need;
      inFlight <= next_inFlight;
      txByte <= next_txByte;
      shStart <= next_shStart;
      wrTaken <= next_wrTaken;
      rdData <= next_rdData;
      rdValid <= next_rdValid;
      crcResult <= next_crcResult;
      cmdBusy <= next_cmdBusy;
      cmdDone <= next_cmdDone;
      cmdTimeout <= next_cmdTimeout;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  busy_resend_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inFlight && shDone && shStatus == `STAT_BUSY) |=>
      shStart && $stable(txByte) && $stable(state))
    else $error("busy byte not resent unchanged");
  every_byte_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inFlight && shDone && shStatus == `STAT_BUSY) |=> inFlight)
    else $error("status poll dropped a byte");
  load_take_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrTaken |-> shStart && txByte == $past(wrData) &&
      $past(state) == loader_pkg::ST_BODY)
    else $error("load byte not taken from source");
  range_param_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (shStart && state == loader_pkg::ST_HEAD && hIdx == 3'h1 &&
      (kind == loader_pkg::K_DUMP || kind == loader_pkg::K_CRC)) |->
      txByte == `RANGE_PARAMS)
    else $error("range parameter count wrong");
  dump_out_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inFlight && shDone && shStatus != `STAT_BUSY &&
      state == loader_pkg::ST_BODY && kind == loader_pkg::K_DUMP) |=>
      rdValid && rdData == $past(shRx))
    else $error("dump byte not delivered");
  crc_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inFlight && shDone && shStatus != `STAT_BUSY &&
      state == loader_pkg::ST_BODY && kind == loader_pkg::K_CRC &&
      cnt == 16'h0001) |=>
      crcResult[15:8] == $past(shRx) && state == loader_pkg::ST_TRAIL)
    else $error("checksum high byte misplaced");
  erase_page_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (shStart && state == loader_pkg::ST_HEAD && hIdx == 3'h2 &&
      kind == loader_pkg::K_ERASE) |-> txByte == page)
    else $error("erase page byte wrong");
  trailer_end_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (inFlight && shDone && shStatus != `STAT_BUSY &&
      state == loader_pkg::ST_TRAIL && shRx == `TRAILER_BYTE) |=>
      state == loader_pkg::ST_END ##1 cmdDone && !cmdBusy)
    else $error("trailer did not end command");
endmodule : loader_host_engine

// [tb/loader_device_model.sv]
// behavioural loader device answering the host over the serial link
module loader_device_model (
  input wire logic linkClk,
  input wire logic linkDout,
  input wire logic locked,
  output logic linkDin,
  output logic [1:0] linkStatus,
  output logic [7:0] errCode
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cm [1024];
  logic [15:0] dm [256];
  logic [7:0] rx, tx, cmd;
  logic [15:0] addr, cnt, crc;
  int bitN, pos, waitN, nReject;
  bit busy;

  function automatic logic [7:0] rdByte(input bit code,
                                        input logic [15:0] a);
    logic [15:0] w;
    w = code ? cm[a[10:1]] : dm[a[8:1]];
    return a[0] ? w[15:8] : w[7:0];
  endfunction : rdByte

  // first byte of a pair lands in the low half
  task automatic wrByte(input bit code, input logic [15:0] a,
                        input logic [7:0] d);
    if (code && a[0]) cm[a[10:1]][15:8] = d;
    else if (code) cm[a[10:1]][7:0] = d;
    else if (a[0]) dm[a[8:1]][15:8] = d;
    else dm[a[8:1]][7:0] = d;
  endtask : wrByte

  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [7:0] d);
    for (int k = 7; k >= 0; k--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crcStep

  // frame decoder run at the end of each received byte
  task automatic take(input logic [7:0] b);
    bit ld, cd, rng;
    int at, bodyN, trailAt;
    logic [15:0] a;
    linkStatus = 2'h3;
    if (pos == 0)
    begin
      if (!(b inside {8'h11, 8'h20, 8'h21, 8'h30, 8'h31, 8'h40, 8'h41,
                      8'h50, 8'h51, 8'hE0}))
        return;
      errCode = 8'h00;
      // locked group answers nothing, code 03
      if (locked)
      begin
        errCode = 8'h03;
        return;
      end
      cmd = b;
    end
    ld = cmd inside {8'h11, 8'h40, 8'h41, 8'h50, 8'h51};
    cd = cmd inside {8'h20, 8'h30, 8'h40, 8'h50, 8'hE0};
    rng = cmd inside {8'h20, 8'h21, 8'h30, 8'h31};
    // byte during word programming refused with 10
    if (busy && ld && pos >= 4)
    begin
      busy = 0;
      nReject++;
      linkStatus = 2'h2;
      return;
    end
    case (pos)
      1: cnt = {8'h00, b};
      2: addr[7:0] = b;
      3: addr[15:8] = b;
      4: if (rng) cnt[7:0] = b;
      5: if (rng) cnt[15:8] = b;
      default: ;
    endcase
    // code-space loads start on an even byte
    if (pos == 3 && ld && cd) addr[0] = 1'b0;
    at = ld ? 4 : (rng ? 7 : 5);
    bodyN = (ld || cmd[7:4] == 4'h2) ? int'(cnt) : (rng ? 2 : 0);
    trailAt = at + bodyN + int'(ld);
    a = addr + 16'(pos - at);
    if (ld && pos >= at && pos < at + bodyN)
    begin
      // write the word unless only verifying
      if (!(cmd inside {8'h40, 8'h41})) wrByte(cd, a, b);
      if (rdByte(cd, a) !== b) errCode = 8'h05;
      // programming starts after the high byte
      busy = cmd == 8'h50 && a[0];
    end
    // page n erased from n times 200h, then busy
    if (cmd == 8'hE0 && pos == 4)
    begin
      for (int k = 0; k < 256; k++) cm[{addr[1:0], 8'(k)}] = 16'hFFFF;
      waitN = 3;
    end
    // checksum of the range, trailer after a wait
    if (rng && cmd[4] && pos == 6)
    begin
      crc = 16'h0000;
      for (int k = 0; k < int'(cnt); k++)
        crc = crcStep(crc, rdByte(cd, addr + 16'(k)));
      waitN = 2;
    end
    // trailer stays off 3Eh until the work is done
    if (pos >= trailAt && tx == 8'h3E)
    begin
      pos = 0;
      tx = 8'h00;
      return;
    end
    pos++;
    if (pos >= trailAt)
    begin
      tx = waitN > 0 ? 8'h00 : 8'h3E;
      if (waitN > 0) waitN--;
    end
    else if (rng && pos >= 7 && cmd[4])
      tx = pos == 7 ? crc[7:0] : crc[15:8];
    else if (rng && pos >= 7)
      tx = rdByte(cd, addr + 16'(pos - 7));
    else
      tx = 8'h00;
  endtask : take

  initial
  begin
    foreach (cm[i]) cm[i] = 16'hFFFF;
    foreach (dm[i]) dm[i] = 16'h0000;
    bitN = 0;
    pos = 0;
    waitN = 0;
    nReject = 0;
    tx = 8'h00;
    linkDin = 1'b0;
    linkStatus = 2'h3;
    errCode = 8'h00;
  end

  // shift in msb first on the rising link edge
  always @(posedge linkClk)
  begin
    rx = {rx[6:0], linkDout};
    bitN++;
  end

  // next answer bit put out on the falling link edge
  always @(negedge linkClk)
  begin
    if (bitN == 8)
    begin
      bitN = 0;
      take(rx);
      linkDin = tx[7];
    end
    else
      linkDin = tx[7 - bitN];
  end
endmodule : loader_device_model

// [tb/loader_memory_command_engine_tb.sv]
// self-checking bench of the loader host engine against a device model
module loader_memory_command_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, resetn, cmdStart, wrValid, locked, srcLoad;
  logic [7:0] cmdCode, cmdPage, wrData, rdData, errCode;
  logic [15:0] cmdAddr, cmdLength, crcResult, dAddr;
  logic wrTaken, rdValid, cmdBusy, cmdDone, cmdTimeout;
  logic linkClk, linkDout, linkDin;
  logic [1:0] linkStatus;
  logic [7:0] src [64];
  logic [7:0] expC [6];
  logic [7:0] expD [8];
  logic [7:0] got [$];
  logic [7:0] loadCmd [2] = '{8'h11, 8'h51};
  int srcLen, srcIdx, n_fail, comparisons, dLen, vl;

  loader_host_engine #(.POLL_LIMIT(16'h0010)) DUT (.ref_clk(ref_clk),
    .resetn(resetn), .cmdStart(cmdStart), .cmdCode(cmdCode),
    .cmdAddr(cmdAddr), .cmdLength(cmdLength), .cmdPage(cmdPage),
    .wrData(wrData), .wrValid(wrValid), .wrTaken(wrTaken),
    .rdData(rdData), .rdValid(rdValid), .crcResult(crcResult),
    .cmdBusy(cmdBusy), .cmdDone(cmdDone), .cmdTimeout(cmdTimeout),
    .linkClk(linkClk), .linkDout(linkDout), .linkDin(linkDin),
    .linkStatus(linkStatus));
  loader_device_model M (.linkClk(linkClk), .linkDout(linkDout),
    .locked(locked), .linkDin(linkDin), .linkStatus(linkStatus),
    .errCode(errCode));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // byte source advancing after each taken byte
  always @(posedge ref_clk)
  begin : feed
    int n;
    n = srcLoad ? 0 : srcIdx + int'(wrTaken === 1'b1);
    srcIdx <= n;
    wrValid <= n < srcLen;
    wrData <= src[n[5:0]];
  end

  // collect dump bytes
  always @(posedge ref_clk)
    if (rdValid === 1'b1) got.push_back(rdData);

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // checksum expected over the bench copy of a range
  function automatic logic [15:0] crcOf(input bit code, input int n);
    logic [15:0] c;
    logic [7:0] d;
    c = 16'h0000;
    for (int k = 0; k < n; k++)
    begin
      d = code ? expC[k] : expD[k];
      for (int j = 7; j >= 0; j--)
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[j]) ? 16'h8005 : 16'h0000);
    end
    return c;
  endfunction : crcOf

  // issue one command and wait for its completion
  task automatic run(input logic [7:0] c, input logic [15:0] a,
                     input logic [15:0] l);
    int k;
    got.delete();
    @(posedge ref_clk);
    cmdCode <= c;
    cmdAddr <= a;
    cmdLength <= l;
    cmdPage <= a[7:0];
    cmdStart <= 1'b1;
    srcLoad <= 1'b1;
    @(posedge ref_clk);
    cmdStart <= 1'b0;
    srcLoad <= 1'b0;
    #1;
    check("cmdBusy", 16'h0001, {15'h0000, cmdBusy});
    for (k = 0; k < 20000 && cmdDone !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    if (k == 20000)
    begin
      n_fail++;
      $display("ERROR cmdDone expected 1 seen 0");
      tally_and_finish();
    end
  endtask : run

  initial
  begin
    void'($urandom(47652));
    {resetn, cmdStart, srcLoad, locked} = 4'h0;
    {cmdCode, cmdPage} = 16'h0000;
    {cmdAddr, cmdLength} = 32'h0000_0000;
    srcLen = 0;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (loadCmd[j])
    begin
      dLen = 2 + $urandom_range(6);
      dAddr = 16'($urandom_range(120)) << 1;
      for (int k = 0; k < dLen; k++) expD[k] = 8'($urandom);
      for (int k = 0; k < dLen; k++) src[k] = expD[k];
      srcLen = dLen;
      run(loadCmd[j], dAddr, 16'(dLen));
      check("word", {expD[1], expD[0]}, M.dm[dAddr[8:1]]);
      check("errCode", 16'h0000, errCode);
      srcLen = 0;
      run(8'h21, dAddr, 16'(dLen));
      check("count", 16'(dLen), 16'(got.size()));
      foreach (got[k]) check("dump", expD[k], got[k]);
      $display("test load %h done", loadCmd[j]);
    end
    for (int k = 0; k < 6; k++) expC[k] = 8'($urandom);
    for (int k = 0; k < 6; k++) src[k] = expC[k];
    srcLen = 6;
    run(8'h50, 16'h01FD, 16'h0006);
    check("errCode", 16'h0000, errCode);
    check("rejects", 16'h0001, 16'(M.nReject > 0));
    srcLen = 0;
    run(8'h20, 16'h01FC, 16'h0006);
    foreach (got[k]) check("code", expC[k], got[k]);
    check("count", 16'h0006, 16'(got.size()));
    $display("test code load done");
    for (int m = 0; m < 4; m++)
    begin
      vl = m[1] ? 6 : dLen;
      for (int k = 0; k < vl; k++) src[k] = m[1] ? expC[k] : expD[k];
      if (m[0]) src[$urandom_range(vl - 1)] ^= 8'hFF;
      srcLen = vl;
      run(m[1] ? 8'h40 : 8'h41, m[1] ? 16'h01FC : dAddr, 16'(vl));
      check("verify", m[0] ? 16'h0005 : 16'h0000, errCode);
    end
    $display("test verify done");
    srcLen = 0;
    run(8'h31, dAddr, 16'(dLen));
    check("crc", crcOf(1'b0, dLen), crcResult);
    run(8'h30, 16'h01FC, 16'h0006);
    check("crc", crcOf(1'b1, 6), crcResult);
    $display("test crc done");
    run(8'hE0, 16'h0001, 16'h0000);
    check("cmdTimeout", 16'h0000, {15'h0000, cmdTimeout});
    run(8'h20, 16'h01FC, 16'h0006);
    foreach (got[k]) check("erase", k < 4 ? expC[k] : 8'hFF, got[k]);
    $display("test erase done");
    locked = 1'b1;
    run(8'h21, 16'h0000, 16'h0000);
    check("cmdTimeout", 16'h0001, {15'h0000, cmdTimeout});
    check("errCode", 16'h0003, errCode);
    locked = 1'b0;
    @(posedge ref_clk);
    cmdCode <= 8'h77;
    cmdStart <= 1'b1;
    @(posedge ref_clk);
    cmdStart <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("cmdBusy", 16'h0000, {15'h0000, cmdBusy});
    $display("test lock and unknown done");
    tally_and_finish();
  end
endmodule : loader_memory_command_engine_tb
